//--- include/ptrd_pkg.sv
// constants and types for the pulse-train reference decoder
`default_nettype none
package ptrd_pkg;
  localparam int unsigned POS_WIDTH       = 32;
  localparam int unsigned FMT_WIDTH       = 2;
  // format codes of format_select_field
  localparam logic [1:0]  FMT_QUADRATURE  = 2'h0;
  localparam logic [1:0]  FMT_CW_CCW      = 2'h1;
  localparam logic [1:0]  FMT_PULSE_DIR   = 2'h2;
  localparam logic [1:0]  FMT_RESET       = 2'h0;
  localparam logic        INVERT_RESET    = 1'h0;
  // source pulse limits, checked on the far side only
  localparam int unsigned CLOCK_HZ        = 100_000_000;
  localparam int unsigned MAX_RATE_FAST_HZ = 4_000_000;
  localparam int unsigned MAX_RATE_DIFF_HZ = 500_000;
  localparam int unsigned MAX_RATE_OC_HZ   = 200_000;
  localparam int unsigned MIN_CYCLES_FAST  = CLOCK_HZ / MAX_RATE_FAST_HZ;
  typedef logic signed [POS_WIDTH-1:0] ptrd_pos_t;
  typedef logic [FMT_WIDTH-1:0] ptrd_fmt_t;
endpackage : ptrd_pkg
`default_nettype wire

//--- logic/ptrd_sync.sv
// two-stage synchroniser for one pin
`default_nettype none
module ptrd_sync (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic nrst_in,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      level_out
);
  logic meta;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta      <= pin_in;
      level_out <= meta;
    end
  end
endmodule : ptrd_sync
`default_nettype wire

//--- logic/ptrd_decoder.sv
// pulse-train reference decoder top
`default_nettype none
module ptrd_decoder
  import ptrd_pkg::*;
(
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               nrst_in,
  // reference_train_port pins
  input  wire logic               fast_step_line_in,
  input  wire logic               fast_direction_line_in,
  // configuration
  input  wire logic               train_following_mode_in,
  input  wire ptrd_pkg::ptrd_fmt_t format_select_field_in,
  input  wire logic               direction_invert_field_in,
  // position reference
  output var ptrd_pkg::ptrd_pos_t position_out,
  output logic                    step_up_out,
  output logic                    step_down_out
);
  import ptrd_pkg::*;

  logic      step_s;
  logic      dir_s;
  logic      step_d;
  logic      dir_d;
  ptrd_fmt_t fmt;
  logic      invert;
  logic      raw_up;
  logic      raw_down;
  logic      up;
  logic      down;

  // rising edge of a synchronised level against its delayed copy
  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : rose

  ptrd_sync u_step_sync (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .pin_in    (fast_step_line_in),
    .level_out (step_s)
  );

  ptrd_sync u_dir_sync (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .pin_in    (fast_direction_line_in),
    .level_out (dir_s)
  );

  // configuration registers; reset defaults, then follow the inputs
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt    <= FMT_RESET;
      invert <= INVERT_RESET;
    end else begin
      fmt    <= format_select_field_in;
      invert <= direction_invert_field_in;
    end
  end

  // previous synchronised levels for edge detection
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_d <= 1'b0;
      dir_d  <= 1'b0;
    end else begin
      step_d <= step_s;
      dir_d  <= dir_s;
    end
  end

  // decode; an edge on both lines in one cycle is a lost quadrature state, ignored
  always_comb begin
    raw_up   = 1'b0;
    raw_down = 1'b0;
    case (fmt)
      FMT_QUADRATURE: begin
        if (train_following_mode_in) begin
          // the moving line that now equals the other one was the trailing edge
          if ((step_s != step_d) && (dir_s == dir_d)) begin
            raw_up   = (step_s == dir_s);
            raw_down = (step_s != dir_s);
          end else if ((dir_s != dir_d) && (step_s == step_d)) begin
            raw_up   = (dir_s != step_s);
            raw_down = (dir_s == step_s);
          end
        end
      end
      FMT_CW_CCW: begin
        // simultaneous pulses cancel
        raw_up   = rose(step_s, step_d) & ~rose(dir_s, dir_d);
        raw_down = rose(dir_s, dir_d) & ~rose(step_s, step_d);
      end
      FMT_PULSE_DIR: begin
        raw_up   = rose(step_s, step_d) & ~dir_s;
        raw_down = rose(step_s, step_d) & dir_s;
      end
      default: begin
        raw_up   = 1'b0;
        raw_down = 1'b0;
      end
    endcase
    up   = invert ? raw_down : raw_up;
    down = invert ? raw_up : raw_down;
  end

  // position accumulator, wraps silently at full scale
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      position_out  <= '0;
      step_up_out   <= 1'b0;
      step_down_out <= 1'b0;
    end else begin
      step_up_out   <= up;
      step_down_out <= down;
      if (up) begin
        position_out <= position_out + ptrd_pos_t'(1);
      end else if (down) begin
        position_out <= position_out - ptrd_pos_t'(1);
      end
    end
  end
endmodule : ptrd_decoder
`default_nettype wire

//--- tb/ptrd_sva.sv
// port assertions for the pulse-train decoder
`default_nettype none
module ptrd_sva (
  input wire logic clock_in, nrst_in, fast_step_line_in, fast_direction_line_in,
  input wire logic train_following_mode_in, direction_invert_field_in, step_up_out,
  input wire logic step_down_out,
  input wire ptrd_pkg::ptrd_fmt_t format_select_field_in,
  input wire ptrd_pkg::ptrd_pos_t position_out);
  timeunit 1ns;
  timeprecision 1ns;
  wire s = fast_step_line_in, d = fast_direction_line_in, m = train_following_mode_in;
  wire i = direction_invert_field_in, u = step_up_out, w = step_down_out;
  wire [1:0] f = format_select_field_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  AST_INC: assert property (u |-> position_out == $past(position_out) + 1)
    else $error("up");
  AST_DEC: assert property (w |-> position_out == $past(position_out) - 1)
    else $error("dn");
  AST_RST: assert property (disable iff (1'b0) !nrst_in |-> position_out == 0 && !u)
    else $error("rst");
  // mode is not synchronised, so give the pipeline four quiet cycles
  AST_QOFF: assert property ((f == 0 && !m)[*4] |-> !u && !w) else $error("qoff");
  AST_QUP: assert property ($rose(d) && !s && f == 0 && m && !i |-> ##3 u)
    else $error("qup");
  AST_QDN: assert property ($rose(s) && !d && f == 0 && m && !i |-> ##3 w)
    else $error("qdn");
  AST_CCW: assert property ($rose(s) && !$rose(d) && f == 1 && !i |-> ##3 u)
    else $error("ccw");
  AST_PD: assert property ($rose(s) && f == 2 |-> ##3 (d ^ i ? w : u))
    else $error("pd");
  cover property (u && f == 0);
  cover property (w && f == 1);
  cover property (u && i);
endmodule : ptrd_sva
bind ptrd_decoder ptrd_sva ptrd_sva_inst (.*);
`default_nettype wire

//--- tb/ptrd_ctrl_model.sv
// motion controller model driving step and direction lines
`default_nettype none
module ptrd_ctrl_model
  import ptrd_pkg::*;
(
  input  wire logic clock_in,
  output logic      step_out,
  output logic      dir_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {step_out, dir_out} = 2'h0;
  // each level is held half a fast period or longer, so the rate stays within limit
  task automatic move(input logic ns, input logic nd);
    @(posedge clock_in);
    step_out <= ns;
    dir_out  <= nd;
    repeat (MIN_CYCLES_FAST / 2) @(posedge clock_in);
  endtask : move
endmodule : ptrd_ctrl_model
`default_nettype wire

//--- tb/ptrd_tb.sv
// self-checking bench for the pulse-train decoder
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module pulse_train_reference_decoder_tb;
  import ptrd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic      clock_in, nrst_in, mode, inv, s, d, up, dn;
  int        n_up, n_dn;
  ptrd_fmt_t fmt;
  ptrd_pos_t pos, exp_pos;
  int        seed = 32'h6f24, error_cnt, n_compared;
  ptrd_decoder ptrd_decoder_inst (.clock_in(clock_in), .nrst_in(nrst_in), .fast_step_line_in(s),
    .fast_direction_line_in(d), .train_following_mode_in(mode), .format_select_field_in(fmt),
    .direction_invert_field_in(inv), .position_out(pos), .step_up_out(up), .step_down_out(dn));
  // step pulses last one cycle, so tally them to check against the count
  always @(posedge clock_in) begin
    n_up += int'(up === 1'b1);
    n_dn += int'(dn === 1'b1);
  end
  ptrd_ctrl_model ptrd_ctrl_model_inst (.clock_in(clock_in), .step_out(s), .dir_out(d));
  function automatic int dlt(ptrd_fmt_t f, logic m, i, s0, d0, s1, d1);
    int r;
    r = 0;
    if (f == 2'h0 && m) r = (s1 != s0) ? ((s1 == d1) ? 1 : -1) : ((d1 != s1) ? 1 : -1);
    if (f == 2'h1) r = int'(s1 & !s0) - int'(d1 & !d0);
    if (f == 2'h2 && s1 && !s0) r = d1 ? -1 : 1;
    return i ? -r : r;
  endfunction : dlt
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    repeat (8000) @(posedge clock_in);
    error_cnt++;
    end_sim();
  end
  initial begin : main
    bit t;
    {nrst_in, mode, inv, fmt} = 5'h00;
    exp_pos = 0;
    repeat (6) @(posedge clock_in);
    `CHK(pos, exp_pos)
    nrst_in <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      mode <= k[3];
      inv <= k[2];
      fmt <= k[1:0];
      repeat (3) @(posedge clock_in);
      // the first two moves of every test are step edges on purpose
      for (int n = 0; n < 20; n++) begin
        t = n < 2 || $random(seed) % 2;
        exp_pos += dlt(fmt, mode, inv, s, d, s ^ t, d ^ !t);
        ptrd_ctrl_model_inst.move(s ^ t, d ^ !t);
        `CHK(pos, exp_pos)
        `CHK(pos, ptrd_pos_t'(n_up - n_dn))
      end
      $display("test %0d done", k);
    end
    end_sim();
  end
endmodule : pulse_train_reference_decoder_tb
`default_nettype wire
